/* File: verilog/pmux_top.sv */
// Purpose: output-function mux for ports six and seven, AXI4-Lite registers
// Assumes: peripheral outputs come from logic on clk_i
// Notes:   illegal select codes fall back to plain port behaviour
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "pmux_defines.svh"
module pmux_top (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               ce_i,
    input  wire pmux_pkg::pmux_byte_t s_axi_awaddr_i,
    input  wire logic               s_axi_awvalid_i,
    output logic                    s_axi_awready_o,
    input  wire logic [31:0]        s_axi_wdata_i,
    input  wire logic [3:0]         s_axi_wstrb_i,
    input  wire logic               s_axi_wvalid_i,
    output logic                    s_axi_wready_o,
    output logic [1:0]              s_axi_bresp_o,
    output logic                    s_axi_bvalid_o,
    input  wire logic               s_axi_bready_i,
    input  wire pmux_pkg::pmux_byte_t s_axi_araddr_i,
    input  wire logic               s_axi_arvalid_i,
    output logic                    s_axi_arready_o,
    output logic [31:0]             s_axi_rdata_o,
    output logic [1:0]              s_axi_rresp_o,
    output logic                    s_axi_rvalid_o,
    input  wire logic               s_axi_rready_i,
    input  wire logic               request_to_send_ch0_i,
    input  wire logic               serial_clock_ch0_i,
    input  wire logic               transmit_data_ch0_i,
    input  wire logic               bus_clock_out_ch0_i,
    input  wire logic               simple_serial_tx_ch0_i,
    input  wire logic               request_to_send_ch1_i,
    input  wire logic               serial_clock_ch1_i,
    input  wire logic               transmit_data_ch1_i,
    input  wire logic               bus_clock_out_ch1_i,
    input  wire logic               simple_serial_tx_ch1_i,
    input  wire logic               transmit_data_ch2_i,
    input  wire logic               bus_clock_out_ch2_i,
    input  wire logic               simple_serial_tx_ch2_i,
    input  wire logic               serial_clock_ch2_i,
    input  wire logic               request_to_send_ch2_i,
    input  wire logic               timer_a0_output_i,
    input  wire logic               timer_a1_output_i,
    input  wire logic               timer_a2_output_i,
    input  wire logic               timer_a3_output_i,
    input  wire logic               motor_phase_v_i,
    input  wire logic               motor_phase_v_n_i,
    input  wire logic               motor_phase_w_i,
    input  wire logic               motor_phase_w_n_i,
    input  wire logic               intelligent_serial_tx_ch0_i,
    input  wire logic               intelligent_serial_tx_ch1_i,
    input  wire logic               intelligent_serial_clock_ch0_i,
    input  wire logic               intelligent_serial_clock_ch1_i,
    input  wire pmux_pkg::pmux_byte_t p6_in_i,
    input  wire pmux_pkg::pmux_byte_t p7_in_i,
    output pmux_pkg::pmux_byte_t    p6_out_o,
    output pmux_pkg::pmux_byte_t    p6_oe_o,
    output pmux_pkg::pmux_byte_t    p7_out_o,
    output pmux_pkg::pmux_byte_t    p7_oe_o,
    output pmux_pkg::pmux_byte_t    p6_pullup_o,
    output pmux_pkg::pmux_byte_t    p7_pullup_o
);
    import pmux_pkg::*;

    pmux_state_s s_ff;
    pmux_state_s nxt_s;
    logic [15:0] pin_sync;
    pmux_byte_t  p6_per;
    pmux_byte_t  p6_ill;
    pmux_byte_t  p7_per;
    pmux_byte_t  p7_ill;

    pmux_sync2 u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i  (ce_i),
        .d_i   ({p7_in_i, p6_in_i}),
        .q_o   (pin_sync)
    );

    function automatic logic mapped(input pmux_byte_t a);
        case (a)
            `PMUX_OFF_P6_DATA, `PMUX_OFF_P6_DIR, `PMUX_OFF_P7_DATA, `PMUX_OFF_P7_DIR,
            `PMUX_OFF_P6_FT, `PMUX_OFF_P6_ST, `PMUX_OFF_P7_FT, `PMUX_OFF_P7_ST,
            `PMUX_OFF_P7_TT, `PMUX_OFF_P7_FO, `PMUX_OFF_PULLUP, `PMUX_OFF_PIN_IN,
            `PMUX_OFF_ILLEGAL: mapped = 1'b1;
            default:           mapped = 1'b0;
        endcase
    endfunction

    // peripheral choice per port-six pin
    assign p6_per[0] = request_to_send_ch0_i;
    assign p6_per[1] = serial_clock_ch0_i;
    assign p6_per[2] = s_ff.st6[2] ? simple_serial_tx_ch0_i : bus_clock_out_ch0_i;
    assign p6_per[3] = transmit_data_ch0_i;
    assign p6_per[4] = request_to_send_ch1_i;
    assign p6_per[5] = serial_clock_ch1_i;
    assign p6_per[6] = s_ff.st6[6] ? simple_serial_tx_ch1_i : bus_clock_out_ch1_i;
    assign p6_per[7] = transmit_data_ch1_i;
    // forbidden code on pin 4 is treated as no function
    assign p6_ill    = {3'h0, s_ff.st6[4], 4'h0};

    // peripheral choice per port-seven pin
    assign p7_per[0] = s_ff.st7[0] ? timer_a0_output_i : transmit_data_ch2_i;
    assign p7_per[1] = s_ff.st7[1] ? simple_serial_tx_ch2_i : bus_clock_out_ch2_i;
    assign p7_per[2] = s_ff.st7[2] ? timer_a1_output_i :
                       (s_ff.tt7[2] ? motor_phase_v_i : serial_clock_ch2_i);
    assign p7_per[3] = s_ff.st7[3] ? motor_phase_v_n_i :
                       (s_ff.tt7[3] ? intelligent_serial_tx_ch1_i : request_to_send_ch2_i);
    assign p7_per[4] = s_ff.st7[4] ? motor_phase_w_i :
                       (s_ff.tt7[4] ? intelligent_serial_clock_ch1_i : timer_a2_output_i);
    assign p7_per[5] = motor_phase_w_n_i;
    assign p7_per[6] = s_ff.st7[6] ? timer_a3_output_i : intelligent_serial_tx_ch0_i;
    // third-tier bit 7 belongs to another port and is ignored here
    assign p7_per[7] = intelligent_serial_clock_ch0_i;
    // second tier wins over third tier, so a stale third-tier bit is harmless while the second-tier bit is set
    assign p7_ill[0] = ~s_ff.st7[0] & s_ff.tt7[0];
    assign p7_ill[1] = ~s_ff.st7[1] & s_ff.tt7[1];
    assign p7_ill[4:2] = 3'h0;
    assign p7_ill[5] = s_ff.st7[5];
    assign p7_ill[6] = ~s_ff.st7[6] & (s_ff.tt7[6] | s_ff.fo7[6]);
    assign p7_ill[7] = s_ff.st7[7];

    always_comb begin
        logic       use6;
        logic       use7;
        logic [1:0] resp;
        nxt_s = s_ff;
        use6  = 1'b0;
        use7  = 1'b0;
        resp  = `PMUX_RESP_OKAY;
        if (ce_i) begin
            // pin drive: peripheral only with first tier set and legal code
            for (int i = 0; i < 8; i++) begin
                use6 = s_ff.ft6[i] & ~p6_ill[i];
                use7 = s_ff.ft7[i] & ~p7_ill[i];
                nxt_s.p6_out[i] = use6 ? p6_per[i] : s_ff.p6_dat[i];
                nxt_s.p6_oe[i]  = use6 | s_ff.p6_dir[i];
                nxt_s.p7_out[i] = use7 ? p7_per[i] : s_ff.p7_dat[i];
                nxt_s.p7_oe[i]  = use7 | s_ff.p7_dir[i];
            end
            // open-drain: drive low only, release for high
            nxt_s.p7_oe[1:0]  = nxt_s.p7_oe[1:0] & ~nxt_s.p7_out[1:0];
            nxt_s.p7_out[1:0] = 2'h0;

            // pull-up acts only on undriven pins
            nxt_s.p6_pu = s_ff.pu6 & ~nxt_s.p6_oe;
            nxt_s.p7_pu = s_ff.pu7 & ~nxt_s.p7_oe & ~`PMUX_P7_OD_MASK;

            // write channel
            if (s_axi_awvalid_i && s_ff.awready) begin
                nxt_s.aw_full = 1'b1;
                nxt_s.aw_addr = s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_ff.wready) begin
                nxt_s.w_full = 1'b1;
                nxt_s.w_data = s_axi_wdata_i;
                nxt_s.w_strb = s_axi_wstrb_i;
            end
            if (s_ff.bvalid && s_axi_bready_i) begin
                nxt_s.bvalid = 1'b0;
            end
            if (s_ff.aw_full && s_ff.w_full && !s_ff.bvalid) begin
                resp = mapped(s_ff.aw_addr) ? `PMUX_RESP_OKAY : `PMUX_RESP_SLVERR;
                if (s_ff.w_strb[0]) begin
                    case (s_ff.aw_addr)
                        `PMUX_OFF_P6_DATA: nxt_s.p6_dat = s_ff.w_data[7:0];
                        `PMUX_OFF_P6_DIR:  nxt_s.p6_dir = s_ff.w_data[7:0];
                        `PMUX_OFF_P7_DATA: nxt_s.p7_dat = s_ff.w_data[7:0];
                        `PMUX_OFF_P7_DIR:  nxt_s.p7_dir = s_ff.w_data[7:0];
                        `PMUX_OFF_P6_FT:   nxt_s.ft6    = s_ff.w_data[7:0];
                        `PMUX_OFF_P6_ST:   nxt_s.st6    = s_ff.w_data[7:0];
                        `PMUX_OFF_P7_FT:   nxt_s.ft7    = s_ff.w_data[7:0];
                        `PMUX_OFF_P7_ST:   nxt_s.st7    = s_ff.w_data[7:0];
                        `PMUX_OFF_P7_TT:   nxt_s.tt7    = s_ff.w_data[7:0];
                        `PMUX_OFF_P7_FO:   nxt_s.fo7    = s_ff.w_data[7:0];
                        `PMUX_OFF_PULLUP:  nxt_s.pu6    = s_ff.w_data[7:0];
                        default: ;
                    endcase
                end
                if (s_ff.w_strb[1] && s_ff.aw_addr == `PMUX_OFF_PULLUP) begin
                    // pins 0,1 of port seven keep no pull-up bit
                    nxt_s.pu7 = s_ff.w_data[`PMUX_PU_P7_LSB +: 8] & ~`PMUX_P7_OD_MASK;
                end
                nxt_s.aw_full = 1'b0;
                nxt_s.w_full  = 1'b0;
                nxt_s.bvalid  = 1'b1;
                nxt_s.bresp   = resp;
            end
            nxt_s.awready = !nxt_s.aw_full;
            nxt_s.wready  = !nxt_s.w_full;

            // read channel
            if (s_ff.rvalid && s_axi_rready_i) begin
                nxt_s.rvalid = 1'b0;
            end
            if (s_axi_arvalid_i && s_ff.arready) begin
                nxt_s.rvalid = 1'b1;
                nxt_s.rresp  = mapped(s_axi_araddr_i) ? `PMUX_RESP_OKAY : `PMUX_RESP_SLVERR;
                case (s_axi_araddr_i)
                    `PMUX_OFF_P6_DATA: nxt_s.rdata = {24'h0, s_ff.p6_dat};
                    `PMUX_OFF_P6_DIR:  nxt_s.rdata = {24'h0, s_ff.p6_dir};
                    `PMUX_OFF_P7_DATA: nxt_s.rdata = {24'h0, s_ff.p7_dat};
                    `PMUX_OFF_P7_DIR:  nxt_s.rdata = {24'h0, s_ff.p7_dir};
                    `PMUX_OFF_P6_FT:   nxt_s.rdata = {24'h0, s_ff.ft6};
                    `PMUX_OFF_P6_ST:   nxt_s.rdata = {24'h0, s_ff.st6};
                    `PMUX_OFF_P7_FT:   nxt_s.rdata = {24'h0, s_ff.ft7};
                    `PMUX_OFF_P7_ST:   nxt_s.rdata = {24'h0, s_ff.st7};
                    `PMUX_OFF_P7_TT:   nxt_s.rdata = {24'h0, s_ff.tt7};
                    `PMUX_OFF_P7_FO:   nxt_s.rdata = {24'h0, s_ff.fo7};
                    // port-seven pins 0,1 pull-up positions always read zero
                    `PMUX_OFF_PULLUP:  nxt_s.rdata = {16'h0, s_ff.pu7, s_ff.pu6};
                    `PMUX_OFF_PIN_IN:  nxt_s.rdata = {16'h0, pin_sync};
                    `PMUX_OFF_ILLEGAL: nxt_s.rdata = {16'h0, p7_ill, p6_ill};
                    default:           nxt_s.rdata = 32'h0;
                endcase
            end
            nxt_s.arready = !nxt_s.rvalid;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign s_axi_awready_o = s_ff.awready;
    assign s_axi_wready_o  = s_ff.wready;
    assign s_axi_bvalid_o  = s_ff.bvalid;
    assign s_axi_bresp_o   = s_ff.bresp;
    assign s_axi_arready_o = s_ff.arready;
    assign s_axi_rvalid_o  = s_ff.rvalid;
    assign s_axi_rresp_o   = s_ff.rresp;
    assign s_axi_rdata_o   = s_ff.rdata;
    assign p6_out_o        = s_ff.p6_out;
    assign p6_oe_o         = s_ff.p6_oe;
    assign p7_out_o        = s_ff.p7_out;
    assign p7_oe_o         = s_ff.p7_oe;
    assign p6_pullup_o     = s_ff.p6_pu;
    assign p7_pullup_o     = s_ff.p7_pu;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    p6_rts_drive_a: assert property ($past(ce_i) && $past(s_ff.ft6[0]) |->
        p6_oe_o[0] && p6_out_o[0] == $past(request_to_send_ch0_i))
        else $error("port six pin 0 does not carry request-to-send 0");
    p6_pin2_choice_a: assert property ($past(ce_i) && $past(s_ff.ft6[2]) |->
        p6_out_o[2] == ($past(s_ff.st6[2]) ? $past(simple_serial_tx_ch0_i)
                                           : $past(bus_clock_out_ch0_i)))
        else $error("port six pin 2 picks the wrong output");
    p6_pin6_choice_a: assert property ($past(ce_i) && $past(s_ff.ft6[6]) |->
        p6_out_o[6] == ($past(s_ff.st6[6]) ? $past(simple_serial_tx_ch1_i)
                                           : $past(bus_clock_out_ch1_i)))
        else $error("port six pin 6 picks the wrong output");
    p7_port_mode_a: assert property ($past(ce_i) && !$past(s_ff.ft7[4]) |->
        p7_oe_o[4] == $past(s_ff.p7_dir[4]) && p7_out_o[4] == $past(s_ff.p7_dat[4]))
        else $error("port seven pin 4 left port mode");
    p7_timer_od_a: assert property ($past(ce_i) && $past(s_ff.ft7[0]) && $past(s_ff.st7[0]) |->
        p7_oe_o[0] == !$past(timer_a0_output_i))
        else $error("port seven pin 0 does not follow timer A0");
    p7_pin4_tier3_a: assert property ($past(ce_i) && $past(s_ff.ft7[4]) && !$past(s_ff.st7[4]) |->
        p7_out_o[4] == ($past(s_ff.tt7[4]) ? $past(intelligent_serial_clock_ch1_i)
                                           : $past(timer_a2_output_i)))
        else $error("port seven pin 4 third tier choice wrong");
    p7_pin6_fall_a: assert property ($past(ce_i) && $past(s_ff.ft7[6]) && $past(s_ff.st7[6] == 1'b0)
        && $past(s_ff.tt7[6] == 1'b0) && $past(s_ff.fo7[6] == 1'b0) |->
        p7_oe_o[6] && p7_out_o[6] == $past(intelligent_serial_tx_ch0_i))
        else $error("port seven pin 6 does not carry intelligent tx 0");
    p7_pin7_clk_a: assert property ($past(ce_i) && $past(s_ff.ft7[7]) && !$past(s_ff.st7[7]) |->
        p7_oe_o[7] && p7_out_o[7] == $past(intelligent_serial_clock_ch0_i))
        else $error("port seven pin 7 does not carry intelligent clock 0");
    open_drain_low_a: assert property (p7_out_o[1:0] == 2'h0 && p7_pullup_o[1:0] == 2'h0)
        else $error("open-drain pin drives high or is pulled up");
    reset_inputs_a: assert property ($past(s_ff.p6_dir == 8'h00) && $past(s_ff.ft6 == 8'h00) |->
        p6_oe_o == 8'h00 ##1 (s_ff.p6_dir != 8'h00 || s_ff.ft6 != 8'h00 || p6_oe_o == 8'h00))
        else $error("port six pin driven while in input mode");
endmodule
`default_nettype wire

/* File: shared/pmux_defines.svh */
// Purpose: offsets, field positions, reset values of the port mux
// Assumes: 32-bit AXI4-Lite word per register
// Notes:   byte registers sit in the low lane
`ifndef PMUX_DEFINES_SVH
`define PMUX_DEFINES_SVH
`define PMUX_OFF_P6_DATA  8'h00
`define PMUX_OFF_P6_DIR   8'h04
`define PMUX_OFF_P7_DATA  8'h08
`define PMUX_OFF_P7_DIR   8'h0C
`define PMUX_OFF_P6_FT    8'h10
`define PMUX_OFF_P6_ST    8'h14
`define PMUX_OFF_P7_FT    8'h18
`define PMUX_OFF_P7_ST    8'h1C
`define PMUX_OFF_P7_TT    8'h20
`define PMUX_OFF_P7_FO    8'h24
`define PMUX_OFF_PULLUP   8'h28
`define PMUX_OFF_PIN_IN   8'h2C
`define PMUX_OFF_ILLEGAL  8'h30
`define PMUX_PU_P7_LSB    8
`define PMUX_P7_OD_MASK   8'h03
`define PMUX_REG_RST      8'h00
`define PMUX_RESP_OKAY    2'h0
`define PMUX_RESP_SLVERR  2'h2
`endif

/* File: shared/pmux_pkg.sv */
// Purpose: types of the port six/seven output mux
// Assumes: nothing
// Notes:   one struct holds all state of the top module
package pmux_pkg;
    typedef logic [7:0] pmux_byte_t;
    typedef struct packed {
        pmux_byte_t  p6_dat;
        pmux_byte_t  p6_dir;
        pmux_byte_t  p7_dat;
        pmux_byte_t  p7_dir;
        pmux_byte_t  ft6;
        pmux_byte_t  st6;
        pmux_byte_t  ft7;
        pmux_byte_t  st7;
        pmux_byte_t  tt7;
        pmux_byte_t  fo7;
        pmux_byte_t  pu6;
        pmux_byte_t  pu7;
        logic        aw_full;
        pmux_byte_t  aw_addr;
        logic        w_full;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        pmux_byte_t  p6_out;
        pmux_byte_t  p6_oe;
        pmux_byte_t  p7_out;
        pmux_byte_t  p7_oe;
        pmux_byte_t  p6_pu;
        pmux_byte_t  p7_pu;
    } pmux_state_s;
    typedef struct packed {
        logic [15:0] s1;
        logic [15:0] s2;
    } pmux_sync_s;
endpackage

/* File: verilog/pmux_sync2.sv */
// Purpose: two-flop synchroniser for the pin inputs
// Assumes: pins are asynchronous to clk_i
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module pmux_sync2 (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic [15:0] d_i,
    output logic      [15:0] q_o
);
    import pmux_pkg::*;
    pmux_sync_s s_ff;
    pmux_sync_s nxt_s;
    always_comb begin
        nxt_s = s_ff;
        if (ce_i) begin
            nxt_s.s1 = d_i;
            nxt_s.s2 = s_ff.s1;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end
    assign q_o = s_ff.s2;
endmodule
`default_nettype wire

/* File: verif/port_six_seven_output_mux_tb_top.sv */
// Purpose: self-checking bench for the port six/seven output mux
// Assumes: AXI4-Lite offsets and codes from pmux_defines.svh
// Notes:   reset first, then routing rows, clock enable, illegal codes, open drain, pull-ups
`timescale 1ns/1ps
`default_nettype none
`include "pmux_defines.svh"
module port_six_seven_output_mux_tb_top;
    import pmux_pkg::*;
    typedef struct packed {
        logic       p7;
        logic [2:0] b;
        logic       st;
        logic       tt;
        logic [4:0] idx;
    } pmux_tb_row_s;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ce = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rd_d;
    logic [3:0]  wstrb = 4'h0;
    logic [1:0]  rd_r;
    logic [26:0] pv = 27'h0;
    pmux_byte_t  p6_in = 8'h00, p7_in = 8'h00, m;
    logic        awready, wready, bvalid, arready, rvalid, o, oe;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    pmux_byte_t  p6_out, p6_oe, p7_out, p7_oe, p6_pu, p7_pu;
    int          err_total = 0, tests_run = 0;
    pmux_tb_row_s r;
    pmux_tb_row_s rows [27] = '{
        '{0,0,0,0,0}, '{0,1,0,0,1}, '{0,2,0,0,3}, '{0,2,1,0,4}, '{0,3,0,0,2}, '{0,4,0,0,5}, '{0,5,0,0,6},
        '{0,6,0,0,8}, '{0,6,1,0,9}, '{0,7,0,0,7}, '{1,0,1,0,15}, '{1,0,0,0,10}, '{1,1,1,0,12},
        '{1,1,0,0,11}, '{1,2,1,0,16}, '{1,2,0,0,13}, '{1,2,0,1,19}, '{1,3,1,0,20}, '{1,3,0,0,14},
        '{1,3,0,1,24}, '{1,4,1,0,21}, '{1,4,0,0,17}, '{1,4,0,1,26}, '{1,5,0,0,22}, '{1,6,1,0,18},
        '{1,6,0,0,23}, '{1,7,0,0,25}};
    pmux_top dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .request_to_send_ch0_i(pv[0]), .serial_clock_ch0_i(pv[1]), .transmit_data_ch0_i(pv[2]),
        .bus_clock_out_ch0_i(pv[3]), .simple_serial_tx_ch0_i(pv[4]), .request_to_send_ch1_i(pv[5]),
        .serial_clock_ch1_i(pv[6]), .transmit_data_ch1_i(pv[7]), .bus_clock_out_ch1_i(pv[8]),
        .simple_serial_tx_ch1_i(pv[9]), .transmit_data_ch2_i(pv[10]), .bus_clock_out_ch2_i(pv[11]),
        .simple_serial_tx_ch2_i(pv[12]), .serial_clock_ch2_i(pv[13]), .request_to_send_ch2_i(pv[14]),
        .timer_a0_output_i(pv[15]), .timer_a1_output_i(pv[16]), .timer_a2_output_i(pv[17]),
        .timer_a3_output_i(pv[18]), .motor_phase_v_i(pv[19]), .motor_phase_v_n_i(pv[20]),
        .motor_phase_w_i(pv[21]), .motor_phase_w_n_i(pv[22]), .intelligent_serial_tx_ch0_i(pv[23]),
        .intelligent_serial_tx_ch1_i(pv[24]), .intelligent_serial_clock_ch0_i(pv[25]),
        .intelligent_serial_clock_ch1_i(pv[26]), .p6_in_i(p6_in), .p7_in_i(p7_in),
        .p6_out_o(p6_out), .p6_oe_o(p6_oe), .p7_out_o(p7_out), .p7_oe_o(p7_oe),
        .p6_pullup_o(p6_pu), .p7_pullup_o(p7_pu));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic aw, w, b;
        @(posedge clk_i);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw = 1'b1;
        w = 1'b1;
        b = 1'b1;
        for (n = 0; b && n < 200; n++) begin
            @(posedge clk_i);
            if (aw && awready) begin
                awvalid <= 1'b0;
                aw = 1'b0;
            end
            if (w && wready) begin
                wvalid <= 1'b0;
                w = 1'b0;
            end
            if (bvalid) begin
                chk("bresp", {30'h0, bresp}, {30'h0, er});
                bready <= 1'b0;
                b = 1'b0;
            end
        end
        if (b) begin
            err_total++;
            give_verdict();
        end
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
        int n;
        logic ar, rw;
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        ar = 1'b1;
        rw = 1'b1;
        for (n = 0; rw && n < 200; n++) begin
            @(posedge clk_i);
            if (ar && arready) begin
                arvalid <= 1'b0;
                ar = 1'b0;
            end
            if (rvalid) begin
                d = rdata;
                rr = rresp;
                rready <= 1'b0;
                rw = 1'b0;
            end
        end
        if (rw) begin
            err_total++;
            give_verdict();
        end
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        chk("reset pins", {p6_oe, p7_oe, p6_pu, p7_pu}, 32'h0);
        chk("reset ready", {29'h0, awready, wready, arready}, 32'h0);
        rst_i <= 1'b0;
        for (int a = 0; a <= 8'h28; a += 4) begin
            axi_rd(a[7:0], rd_d, rd_r);
            chk("reset reg", rd_d, 32'h0);
            chk("reset resp", {30'h0, rd_r}, {30'h0, `PMUX_RESP_OKAY});
        end
        $display("test reset done");
        foreach (rows[i]) begin
            r = rows[i];
            m = 8'h01 << r.b;
            axi_wr(`PMUX_OFF_P6_FT, r.p7 ? 32'h0 : {24'h0, m}, `PMUX_RESP_OKAY);
            axi_wr(`PMUX_OFF_P6_ST, (!r.p7 && r.st) ? {24'h0, m} : 32'h0, `PMUX_RESP_OKAY);
            axi_wr(`PMUX_OFF_P7_FT, r.p7 ? {24'h0, m} : 32'h0, `PMUX_RESP_OKAY);
            axi_wr(`PMUX_OFF_P7_ST, (r.p7 && r.st) ? {24'h0, m} : 32'h0, `PMUX_RESP_OKAY);
            axi_wr(`PMUX_OFF_P7_TT, r.tt ? {24'h0, m} : 32'h0, `PMUX_RESP_OKAY);
            for (int v = 0; v < 2; v++) begin
                @(posedge clk_i);
                pv <= v[0] ? (27'h1 << r.idx) : ~(27'h1 << r.idx);
                repeat (3) @(posedge clk_i);
                o = r.p7 ? p7_out[r.b] : p6_out[r.b];
                oe = r.p7 ? p7_oe[r.b] : p6_oe[r.b];
                // open-drain pins release for a high and pull low for a low
                chk("pin", {oe, o}, (r.p7 && r.b < 2) ? {~v[0], 1'b0} : {1'b1, v[0]});
            end
        end
        $display("test routing done");
        // last row leaves pin 7 of port seven high; a low enable must hold it
        @(posedge clk_i);
        ce <= 1'b0;
        pv <= 27'h0;
        repeat (3) @(posedge clk_i);
        chk("ce freeze", {30'h0, p7_oe[7], p7_out[7]}, 32'h3);
        ce <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk("ce run", {30'h0, p7_oe[7], p7_out[7]}, 32'h2);
        $display("test clock enable done");
        axi_wr(`PMUX_OFF_P6_DATA, 32'hFF, `PMUX_RESP_OKAY);
        axi_wr(`PMUX_OFF_P6_DIR, 32'h10, `PMUX_RESP_OKAY);
        axi_wr(`PMUX_OFF_P7_DATA, 32'hFC, `PMUX_RESP_OKAY);
        axi_wr(`PMUX_OFF_P7_DIR, 32'hC3, `PMUX_RESP_OKAY);
        axi_wr(`PMUX_OFF_P6_FT, 32'h10, `PMUX_RESP_OKAY);
        axi_wr(`PMUX_OFF_P6_ST, 32'h10, `PMUX_RESP_OKAY);
        axi_wr(`PMUX_OFF_P7_FT, 32'hC0, `PMUX_RESP_OKAY);
        axi_wr(`PMUX_OFF_P7_ST, 32'h80, `PMUX_RESP_OKAY);
        axi_wr(`PMUX_OFF_P7_TT, 32'h00, `PMUX_RESP_OKAY);
        axi_wr(`PMUX_OFF_P7_FO, 32'h40, `PMUX_RESP_OKAY);
        @(posedge clk_i);
        pv <= 27'h0;
        repeat (3) @(posedge clk_i);
        chk("p6 plain", {p6_oe, p6_out & 8'h10}, 16'h1010);
        chk("p7 plain", {p7_oe, p7_out & 8'hC3}, 16'hC3C0);
        axi_rd(`PMUX_OFF_ILLEGAL, rd_d, rd_r);
        chk("illegal status", rd_d, 32'h0000C010);
        axi_wr(`PMUX_OFF_P7_DATA, 32'h01, `PMUX_RESP_OKAY);
        repeat (3) @(posedge clk_i);
        chk("open drain", {30'h0, p7_oe[1:0]}, 32'h2);
        $display("test illegal and open drain done");
        axi_wr(`PMUX_OFF_P6_DIR, 32'h0, `PMUX_RESP_OKAY);
        axi_wr(`PMUX_OFF_P7_DIR, 32'h0, `PMUX_RESP_OKAY);
        axi_wr(`PMUX_OFF_P6_FT, 32'h0, `PMUX_RESP_OKAY);
        axi_wr(`PMUX_OFF_P7_FT, 32'h0, `PMUX_RESP_OKAY);
        axi_wr(`PMUX_OFF_PULLUP, 32'hFFFFFFFF, `PMUX_RESP_OKAY);
        repeat (3) @(posedge clk_i);
        chk("pullup pins", {p7_pu, p6_pu}, 16'hFCFF);
        axi_rd(`PMUX_OFF_PULLUP, rd_d, rd_r);
        chk("pullup reg", rd_d, 32'h0000FCFF);
        $display("test pullup done");
        axi_wr(8'h34, 32'hFF, `PMUX_RESP_SLVERR);
        axi_rd(8'h34, rd_d, rd_r);
        chk("unmapped read", {rd_r, rd_d[29:0]}, {`PMUX_RESP_SLVERR, 30'h0});
        @(posedge clk_i);
        p6_in <= 8'h5A;
        p7_in <= 8'hA5;
        axi_wr(`PMUX_OFF_PIN_IN, 32'hFFFF, `PMUX_RESP_OKAY);
        axi_rd(`PMUX_OFF_PIN_IN, rd_d, rd_r);
        chk("pin inputs", rd_d, 32'h0000A55A);
        $display("test bus edges done");
        give_verdict();
    end
endmodule
`default_nettype wire
